// ---- test/lcir_regs_tb.sv ----
// self-checking bench for the lcd irq and contrast register block
`timescale 1ns/1ps
module lcir_regs_tb;
    import lcir_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic contrast_pwm;
    logic [5:0] ev = 6'h00;
    logic [31:0] rd;
    logic [31:0] exp;
    logic err;
    logic [31:0] n;
    logic lvl;
    int bad_count = 0;
    int checked = 0;
    int bitpos [6] = '{LCIR_BIT_ROW, LCIR_BIT_LAST, LCIR_BIT_EOF,
                       LCIR_BIT_UFLW, LCIR_BIT_OVWR, LCIR_BIT_MERR};

    always #50 pclk = ~pclk;

    lcir_regs i_lcir_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .row_event(ev[0]),
        .final_row_event(ev[1]),
        .frame_done_event(ev[2]),
        .queue_starved_event(ev[3]),
        .queue_overrun_event(ev[4]),
        .fetch_fault_event(ev[5]),
        .irq(irq),
        .contrast_pwm(contrast_pwm)
    );

    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got,
                     want);
        end
    endtask : cmp

    // one idle edge before each setup so no signal is driven twice at once
    task automatic apb_xfer(input logic [11:0] a, input logic wr,
                            input logic [31:0] d, output logic [31:0] q,
                            output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb_xfer

    task automatic apb_write(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb_xfer(a, 1'b1, d, q, e);
    endtask : apb_write

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] want);
        logic [31:0] q;
        logic e;
        apb_xfer(a, 1'b0, 32'h0, q, e);
        cmp(q, want);
    endtask : rd_chk

    task automatic irq_chk(input logic want);
        @(negedge pclk);
        cmp({31'h0, irq}, {31'h0, want});
    endtask : irq_chk

    task complete_run;
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // the pwm divider sweep dominates: under about ten thousand cycles
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(LCIR_OFF_COMPARE_LEVEL, 32'h0);
        rd_chk(LCIR_OFF_IMASK, 32'h0);
        rd_chk(LCIR_OFF_ISTAT, 32'h0);
        rd_chk(LCIR_OFF_IRAW, 32'h0);
        irq_chk(1'b0);
        $display("test reset done");
        apb_write(LCIR_OFF_COMPARE_LEVEL, 32'hffff_ffa5);
        rd_chk(LCIR_OFF_COMPARE_LEVEL, 32'h0000_00a5);
        apb_write(LCIR_OFF_IEN, 32'hffff_ffff);
        rd_chk(LCIR_OFF_IMASK, 32'h77);
        apb_write(LCIR_OFF_IDIS, 32'h05);
        rd_chk(LCIR_OFF_IMASK, 32'h72);
        apb_write(LCIR_OFF_IEN, 32'h0);
        rd_chk(LCIR_OFF_IMASK, 32'h72);
        apb_write(LCIR_OFF_IDIS, 32'h0);
        rd_chk(LCIR_OFF_IMASK, 32'h72);
        apb_write(LCIR_OFF_IMASK, 32'h0);
        rd_chk(LCIR_OFF_IMASK, 32'h72);
        $display("test mask done");
        // mask 0x72 leaves row and frame-done masked, so irq differs
        for (int i = 0; i < 6; i++) begin
            exp = 32'h1 << bitpos[i];
            @(posedge pclk);
            ev[i] <= 1'b1;
            @(posedge pclk);
            ev[i] <= 1'b0;
            rd_chk(LCIR_OFF_IRAW, exp);
            rd_chk(LCIR_OFF_ISTAT, exp & 32'h72);
            irq_chk(|(exp & 32'h72));
            apb_write(LCIR_OFF_ICLR, exp);
            rd_chk(LCIR_OFF_IRAW, 32'h0);
            irq_chk(1'b0);
        end
        $display("test events done");
        apb_write(LCIR_OFF_ITEST, 32'hffff_ffff);
        rd_chk(LCIR_OFF_IRAW, 32'h77);
        apb_write(LCIR_OFF_IRAW, 32'h0);
        rd_chk(LCIR_OFF_IRAW, 32'h77);
        apb_write(LCIR_OFF_ICLR, 32'h70);
        rd_chk(LCIR_OFF_ISTAT, 32'h02);
        irq_chk(1'b1);
        apb_write(LCIR_OFF_IDIS, 32'h02);
        irq_chk(1'b0);
        apb_write(LCIR_OFF_IEN, 32'h01);
        irq_chk(1'b1);
        apb_xfer(12'h0fc, 1'b0, 32'h0, rd, err);
        cmp({31'h0, err}, 32'h1);
        cmp(rd, 32'h0);
        $display("test force and refusal done");
        // compare zero: polarity one never high, polarity zero always high
        apb_write(LCIR_OFF_COMPARE_LEVEL, 32'h0);
        apb_write(LCIR_OFF_CTRL, 32'h0c);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp({31'h0, contrast_pwm}, 32'h0);
        apb_write(LCIR_OFF_CTRL, 32'h08);
        repeat (3) @(posedge pclk);
        @(negedge pclk);
        cmp({31'h0, contrast_pwm}, 32'h1);
        // high time is 128 counts of one divider span each; wait for a
        // fall first so a polarity flip cannot fake the start of a run
        apb_write(LCIR_OFF_COMPARE_LEVEL, 32'h80);
        for (int d = 0; d < 4; d++) begin
            apb_write(LCIR_OFF_CTRL, 32'h0c | d);
            @(negedge contrast_pwm);
            @(posedge contrast_pwm);
            n = 32'h0;
            @(negedge pclk);
            while (contrast_pwm === 1'b1) begin
                n++;
                @(negedge pclk);
            end
            cmp(n, 32'h80 << d);
        end
        rd_chk(LCIR_OFF_CTRL, 32'h0f);
        // run bit low: a running counter would toggle twice in 300 clocks
        apb_write(LCIR_OFF_CTRL, 32'h04);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        lvl = contrast_pwm;
        n = 32'h0;
        repeat (300) begin
            @(negedge pclk);
            if (contrast_pwm !== lvl) begin
                n++;
            end
        end
        cmp(n, 32'h0);
        $display("test pwm done");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(LCIR_OFF_COMPARE_LEVEL, 32'h0);
        rd_chk(LCIR_OFF_CTRL, 32'h0);
        rd_chk(LCIR_OFF_IMASK, 32'h0);
        rd_chk(LCIR_OFF_IRAW, 32'h0);
        irq_chk(1'b0);
        $display("test second reset done");
        complete_run();
    end
endmodule : lcir_regs_tb

// ---- verilog/lcir_pkg.sv ----
// package: register map, field layout and constants of the lcd irq block
package lcir_pkg;
    localparam logic [11:0] LCIR_OFF_CTRL = 12'h000;
    localparam logic [11:0] LCIR_OFF_COMPARE_LEVEL = 12'h004;
    localparam logic [11:0] LCIR_OFF_IEN = 12'h008;
    localparam logic [11:0] LCIR_OFF_IDIS = 12'h00c;
    localparam logic [11:0] LCIR_OFF_IMASK = 12'h010;
    localparam logic [11:0] LCIR_OFF_ISTAT = 12'h014;
    localparam logic [11:0] LCIR_OFF_ICLR = 12'h018;
    localparam logic [11:0] LCIR_OFF_ITEST = 12'h01c;
    localparam logic [11:0] LCIR_OFF_IRAW = 12'h020;

    localparam int LCIR_NSRC = 7;
    localparam logic [6:0] LCIR_SRC_MASK = 7'h77;
    localparam int LCIR_BIT_ROW = 0;
    localparam int LCIR_BIT_LAST = 1;
    localparam int LCIR_BIT_EOF = 2;
    localparam int LCIR_BIT_UFLW = 4;
    localparam int LCIR_BIT_OVWR = 5;
    localparam int LCIR_BIT_MERR = 6;

    localparam int LCIR_CTRL_PS_LSB = 0;
    localparam int LCIR_CTRL_POL = 2;
    localparam int LCIR_CTRL_ENA = 3;

    localparam logic [7:0] LCIR_COMPARE_LEVEL_RST = 8'h00;
    localparam logic [6:0] LCIR_IRQ_RST = 7'h00;
    localparam logic [3:0] LCIR_CTRL_RST = 4'h0;
    localparam logic [2:0] LCIR_DIV_MAX = 3'h7;
endpackage : lcir_pkg

// ---- verilog/lcir_pwm.sv ----
// contrast pwm counter with prescaler and polarity
`timescale 1ns/1ps
module lcir_pwm
    import lcir_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pwm_run,
    input wire logic pwm_output_polarity,
    input wire logic [1:0] pwm_divider_select,
    input wire logic [7:0] compare_level,
    output logic pwm_out,
    output logic [7:0] pwm_count
);
    logic [2:0] div_reg;
    logic [7:0] cnt_reg;
    logic tick;
    logic out_reg;

    always_comb begin
        case (pwm_divider_select)
            2'h0: tick = 1'b1;
            2'h1: tick = div_reg[0];
            2'h2: tick = &div_reg[1:0];
            default: tick = (div_reg == LCIR_DIV_MAX);
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 3'h0;
            cnt_reg <= 8'h00;
        end else if (pwm_run) begin
            div_reg <= div_reg + 3'h1;
            if (tick) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    // high below compare when polarity set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_reg <= 1'b0;
        end else begin
            out_reg <= (cnt_reg < compare_level) ~^ pwm_output_polarity;
        end
    end

    assign pwm_out = out_reg;
    assign pwm_count = cnt_reg;
endmodule : lcir_pwm

// ---- verilog/lcir_regs.sv ----
// apb register set: contrast compare, pwm control and interrupt registers
//
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - 8-bit compare value, read/write, resets zero
// - shared bit layout 0,1,2,4,5,6
// - enable writes set mask bits
// - disable writes clear mask bits
// - mask readable, resets zero
// - status shows active sources, resets zero
// - clear writes drop pending bits
// - test writes force pending bits
// - raw view shows pending before masking
// - row and last-row sources are independent
// - frame done and fetch fault from dma
// - polarity one gives high below compare
// - run bit zero stops counter
// - prescaler divides by 1,2,4,8
module lcir_regs
    import lcir_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic row_event,
    input wire logic final_row_event,
    input wire logic frame_done_event,
    input wire logic queue_starved_event,
    input wire logic queue_overrun_event,
    input wire logic fetch_fault_event,
    output logic irq,
    output logic contrast_pwm
);
    logic [7:0] compare_level_reg;
    logic [3:0] ctrl_reg;
    logic [6:0] mask_reg;
    logic [6:0] mask_next;
    logic [6:0] pend_reg;
    logic [6:0] pend_next;
    logic [6:0] events;
    logic [6:0] wbits;
    logic [6:0] force_bits;
    logic wr;
    logic rd;
    logic known;
    logic [31:0] rdata_next;
    logic [7:0] pwm_count;

    assign wr = psel & penable & pwrite;
    // read data is taken in setup, so the access phase never waits
    assign rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign wbits = pwdata[6:0] & LCIR_SRC_MASK;
    assign force_bits = (wr && paddr == LCIR_OFF_ITEST) ? wbits : 7'h00;

    always_comb begin
        events = 7'h00;
        events[LCIR_BIT_ROW] = row_event;
        events[LCIR_BIT_LAST] = final_row_event;
        events[LCIR_BIT_EOF] = frame_done_event;
        events[LCIR_BIT_UFLW] = queue_starved_event;
        events[LCIR_BIT_OVWR] = queue_overrun_event;
        events[LCIR_BIT_MERR] = fetch_fault_event;
    end

    always_comb begin
        case (paddr)
            LCIR_OFF_CTRL, LCIR_OFF_COMPARE_LEVEL, LCIR_OFF_IEN, LCIR_OFF_IDIS,
            LCIR_OFF_IMASK, LCIR_OFF_ISTAT, LCIR_OFF_ICLR, LCIR_OFF_ITEST,
            LCIR_OFF_IRAW: known = 1'b1;
            default: known = 1'b0;
        endcase
    end
    // unmapped addresses answer with an error, never a hang
    assign pslverr = psel & penable & ~known;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_level_reg <= LCIR_COMPARE_LEVEL_RST;
        end else if (wr && paddr == LCIR_OFF_COMPARE_LEVEL) begin
            compare_level_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= LCIR_CTRL_RST;
        end else if (wr && paddr == LCIR_OFF_CTRL) begin
            ctrl_reg <= pwdata[3:0];
        end
    end

    // set and clear of the mask
    always_comb begin
        mask_next = mask_reg;
        if (wr && paddr == LCIR_OFF_IEN) begin
            mask_next = mask_reg | wbits;
        end
        if (wr && paddr == LCIR_OFF_IDIS) begin
            mask_next = mask_reg & ~wbits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_reg <= LCIR_IRQ_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // clear first, then events and tests win
    always_comb begin
        pend_next = pend_reg;
        if (wr && paddr == LCIR_OFF_ICLR) begin
            pend_next = pend_next & ~wbits;
        end
        pend_next = pend_next | events;
        if (wr && paddr == LCIR_OFF_ITEST) begin
            pend_next = pend_next | wbits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= LCIR_IRQ_RST;
        end else begin
            pend_reg <= pend_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(pend_next & mask_next);
        end
    end

    // raw view is read-only, writes drop
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            LCIR_OFF_CTRL: rdata_next[3:0] = ctrl_reg;
            LCIR_OFF_COMPARE_LEVEL: rdata_next[7:0] = compare_level_reg;
            LCIR_OFF_IMASK: rdata_next[6:0] = mask_reg;
            LCIR_OFF_ISTAT: rdata_next[6:0] = pend_reg & mask_reg;
            LCIR_OFF_IRAW: rdata_next[6:0] = pend_reg;
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // read data held in a flop, captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd) begin
            prdata <= rdata_next;
        end
    end

    lcir_pwm i_lcir_pwm (
        .pclk(pclk),
        .presetn(presetn),
        .pwm_run(ctrl_reg[LCIR_CTRL_ENA]),
        .pwm_output_polarity(ctrl_reg[LCIR_CTRL_POL]),
        .pwm_divider_select(ctrl_reg[LCIR_CTRL_PS_LSB +: 2]),
        .compare_level(compare_level_reg),
        .pwm_out(contrast_pwm),
        .pwm_count(pwm_count)
    );

    property p_enable_sets;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_IEN) |=> ((mask_reg & $past(wbits)) == $past(wbits));
    endproperty
    a_enable_sets: assert property (p_enable_sets)
        else $error("enable write did not set mask");

    property p_disable_clears;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_IDIS) |=> ((mask_reg & $past(wbits)) == 7'h00);
    endproperty
    a_disable_clears: assert property (p_disable_clears)
        else $error("disable write did not clear mask");

    property p_event_pends;
        @(posedge pclk) disable iff (!presetn)
        frame_done_event |=> pend_reg[LCIR_BIT_EOF];
    endproperty
    a_event_pends: assert property (p_event_pends)
        else $error("frame done event lost");

    property p_test_forces;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_ITEST) |=> ((pend_reg & $past(wbits)) == $past(wbits));
    endproperty
    a_test_forces: assert property (p_test_forces)
        else $error("test write did not set pending");

    property p_clear_drops;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_ICLR && events == 7'h00) |=>
            ((pend_reg & $past(wbits)) == 7'h00);
    endproperty
    a_clear_drops: assert property (p_clear_drops)
        else $error("clear write left pending bit");

    property p_irq_level;
        @(posedge pclk) disable iff (!presetn)
        irq == |(pend_reg & mask_reg);
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("irq does not match pending and mask");

    property p_reserved_zero;
        @(posedge pclk) disable iff (!presetn)
        ((pend_reg & ~LCIR_SRC_MASK) == 7'h00) &&
            ((mask_reg & ~LCIR_SRC_MASK) == 7'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved interrupt bit set");

    property p_raw_nowrite;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_IRAW) |=> ((mask_reg == $past(mask_reg)) &&
            (pend_reg == ($past(pend_reg) | $past(events))));
    endproperty
    a_raw_nowrite: assert property (p_raw_nowrite)
        else $error("raw view write changed state");

    property p_pwm_stops;
        @(posedge pclk) disable iff (!presetn)
        (!ctrl_reg[LCIR_CTRL_ENA] && !$past(ctrl_reg[LCIR_CTRL_ENA]))
            |-> $stable(pwm_count);
    endproperty
    a_pwm_stops: assert property (p_pwm_stops)
        else $error("pwm counter moved while stopped");

    property p_compare_level_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_COMPARE_LEVEL) |=> (compare_level_reg == $past(pwdata[7:0]));
    endproperty
    a_compare_level_write: assert property (p_compare_level_write)
        else $error("compare value write lost");

    property p_ctrl_write;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_CTRL) |=> (ctrl_reg == $past(pwdata[3:0]));
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("pwm control write lost");

    property p_compare_level_read;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == LCIR_OFF_COMPARE_LEVEL) |=>
            (prdata == {24'h0, $past(compare_level_reg)});
    endproperty
    a_compare_level_read: assert property (p_compare_level_read)
        else $error("compare value read wrong");

    property p_mask_read;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == LCIR_OFF_IMASK) |=>
            (prdata == {25'h0, $past(mask_reg)});
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask read wrong");

    property p_status_read;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == LCIR_OFF_ISTAT) |=>
            (prdata == {25'h0, $past(pend_reg) & $past(mask_reg)});
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read wrong");

    property p_raw_read;
        @(posedge pclk) disable iff (!presetn)
        (rd && paddr == LCIR_OFF_IRAW) |=>
            (prdata == {25'h0, $past(pend_reg)});
    endproperty
    a_raw_read: assert property (p_raw_read)
        else $error("raw view read wrong");

    property p_mask_hold;
        @(posedge pclk) disable iff (!presetn)
        !(wr && (paddr == LCIR_OFF_IEN || paddr == LCIR_OFF_IDIS)) |=>
            (mask_reg == $past(mask_reg));
    endproperty
    a_mask_hold: assert property (p_mask_hold)
        else $error("mask moved without enable or disable write");

    property p_pend_keep;
        @(posedge pclk) disable iff (!presetn)
        !(wr && paddr == LCIR_OFF_ICLR) |=>
            ((pend_reg & $past(pend_reg)) == $past(pend_reg));
    endproperty
    a_pend_keep: assert property (p_pend_keep)
        else $error("pending bit lost without clear write");

    property p_pend_cause;
        @(posedge pclk) disable iff (!presetn)
        1'b1 |=> ((pend_reg & ~$past(pend_reg) & ~$past(events) &
            ~$past(force_bits)) == 7'h00);
    endproperty
    a_pend_cause: assert property (p_pend_cause)
        else $error("pending bit set with no event or test write");

    property p_irq_on_event;
        @(posedge pclk) disable iff (!presetn)
        ((events & mask_reg) != 7'h00) &&
            !(wr && paddr == LCIR_OFF_IDIS) |=> irq;
    endproperty
    a_irq_on_event: assert property (p_irq_on_event)
        else $error("enabled event did not raise irq");

    // the first edge after reset carries reset history, so skip it
    property p_pwm_level;
        @(posedge pclk) disable iff (!presetn)
        $past(presetn) |->
            (contrast_pwm == (($past(pwm_count) < $past(compare_level_reg)) ~^
                $past(ctrl_reg[LCIR_CTRL_POL])));
    endproperty
    a_pwm_level: assert property (p_pwm_level)
        else $error("pwm level does not follow compare and polarity");

    property p_pwm_runs;
        @(posedge pclk) disable iff (!presetn)
        ($past(ctrl_reg[LCIR_CTRL_ENA]) &&
            ($past(ctrl_reg[LCIR_CTRL_PS_LSB +: 2]) == 2'h0))
            |-> (pwm_count == $past(pwm_count) + 8'h01);
    endproperty
    a_pwm_runs: assert property (p_pwm_runs)
        else $error("undivided pwm counter did not advance");

    c_irq_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(irq));
    c_test_irq: cover property (@(posedge pclk) disable iff (!presetn)
        (wr && paddr == LCIR_OFF_ITEST) ##2 irq);
    c_clear_irq: cover property (@(posedge pclk) disable iff (!presetn)
        $fell(irq));
    c_pwm_rise: cover property (@(posedge pclk) disable iff (!presetn)
        $rose(contrast_pwm));
endmodule : lcir_regs
